/* verilog/can_phy_pkg.sv */
package can_phy_pkg;

	// ****************************************
	// timing and sizes
	// ****************************************
	localparam int CLK_PERIOD_NS   = 25;
	localparam int WAKE_FILTER_NS  = 1000;
	localparam int WAKE_WINDOW_NS  = 1000000;
	localparam int WAKE_FILTER_CYC =
		(WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WAKE_WINDOW_CYC = WAKE_WINDOW_NS / CLK_PERIOD_NS;
	localparam int CNT_W           = 17;
	localparam int NUM_CH          = 2;
	localparam int FIFO_DEPTH      = 16;
	localparam int EVT_W           = 1;

	// ****************************************
	// pin levels
	// ****************************************
	localparam logic RX_RECESSIVE = 1'h1;
	localparam logic RX_DOMINANT  = 1'h0;
	localparam logic OE_DRIVE     = 1'h0;
	localparam logic OE_RELEASE   = 1'h1;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {
		MON_IDLE,
		MON_WAIT_REC,
		MON_WAIT_DOM,
		MON_WOKEN
	} monState_t;

	typedef struct packed {
		logic standby;
		logic txIn;
		logic busDominant;
	} chanIn_t;

	typedef struct packed {
		logic rxOut;
		logic busHighOut;
		logic busHighOe_n;
		logic busLowOut;
		logic busLowOe_n;
		logic biasGround;
	} chanOut_t;

	typedef struct packed {
		logic [EVT_W-1:0] data;
		logic             valid;
	} wakeEvt_t;

endpackage : can_phy_pkg

/* verilog/dual_can_phy_mode_wake.sv */
// Summary of operation
// RULE1 - standby: transmitter off, rx high until wake
// RULE2 - low select: normal mode, both directions active
// RULE3 - normal: tx low drives dominant, else recessive
// RULE4 - standby: bus released, weakly biased to ground
// RULE5 - normal: rx low dominant, high recessive
// RULE6 - wake shown only on own channel
// RULE7 - host sees rx fall, drives select low
// RULE8 - pattern: dominant, recessive, dominant, all filtered
// RULE9 - short activity never resets waiting monitor
// RULE10 - wake: rx falls, low for dominant
// RULE11 - after wake, each filtered dominant pulls rx
// RULE12 - filtered means longer than filter time
// RULE13 - below filter never counts, above always
// RULE14 - filter fits one 500k or two 1M bits
// RULE15 - whole pattern inside window from first dominant
// RULE16 - window expiry resets monitor, no wake
// RULE17 - floating tx recessive, floating select standby
// RULE18 - filter and window are cycle parameters
// RULE19 - two identical independent channels
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// wake event fifo
// ****************************************
module wake_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// fill side
	input  wire logic             inValid,
	input  wire logic [WIDTH-1:0] inData,
	output var  logic             inReady,
	// drain side
	output var  logic             outValid,
	output var  logic [WIDTH-1:0] outData,
	input  wire logic             outReady
);
	import can_phy_pkg::*;

	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               rd;
		logic [AW-1:0]               wr;
		logic [AW:0]                 count;
		logic                        full;
		logic                        valid;
		logic [WIDTH-1:0]            data;
	} fifoState_t;

	fifoState_t st;
	fifoState_t next_st;
	logic       push;
	logic       pop;

	always_comb begin
		next_st = st;
		push = inValid && !st.full;
		pop = st.valid && outReady;
		if (push) begin
			next_st.mem[st.wr] = inData;
			next_st.wr = AW'(st.wr + 1'b1);
		end
		if (pop) begin
			next_st.rd = AW'(st.rd + 1'b1);
		end
		next_st.count = (AW+1)'(st.count + push - pop);
		next_st.full = (next_st.count == (AW+1)'(DEPTH));
		next_st.valid = (next_st.count != '0);
		next_st.data = next_st.mem[next_st.rd];
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign inReady = !st.full;
	assign outValid = st.valid;
	assign outData = st.data;

endmodule : wake_fifo

// ****************************************
// one transceiver channel
// ****************************************
module can_phy_channel #(
	parameter int FILTER_CYC = 40,
	parameter int WINDOW_CYC = 40000
) (
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	// pins
	input  wire can_phy_pkg::chanIn_t  pinIn,
	output var  can_phy_pkg::chanOut_t pinOut,
	// wake event
	output var  logic                  evtPend,
	input  wire logic                  evtTaken
);
	import can_phy_pkg::*;

	typedef struct packed {
		monState_t         mon;
		logic              lastDom;
		logic [CNT_W-1:0]  runCnt;
		logic              filtDom;
		logic [CNT_W-1:0]  winCnt;
		logic              pend;
		chanOut_t          out;
	} chanState_t;

	chanState_t st;
	chanState_t next_st;
	logic       runFiltered;
	logic       newDom;
	logic       newRec;

	always_comb begin
		next_st = st;
		// run length of current bus state
		next_st.lastDom = pinIn.busDominant;
		if (pinIn.busDominant != st.lastDom) begin
			next_st.runCnt = CNT_W'(1);
		end else if (st.runCnt <= CNT_W'(FILTER_CYC)) begin
			next_st.runCnt = CNT_W'(st.runCnt + 1'b1);
		end
		// RULE12 strictly longer than filter
		// RULE13 RULE14 exact cycle threshold
		runFiltered = (next_st.runCnt > CNT_W'(FILTER_CYC));
		newDom = runFiltered && pinIn.busDominant
			&& (st.runCnt == CNT_W'(FILTER_CYC));
		newRec = runFiltered && !pinIn.busDominant
			&& (st.runCnt == CNT_W'(FILTER_CYC));
		next_st.filtDom = runFiltered && pinIn.busDominant;
		if (st.winCnt < CNT_W'(WINDOW_CYC)) begin
			next_st.winCnt = CNT_W'(st.winCnt + 1'b1);
		end
		// RULE2 normal mode, monitor idle
		if (!pinIn.standby) begin
			next_st.mon = MON_IDLE;
			// RULE5 rx mirrors bus
			next_st.out.rxOut = pinIn.busDominant ? RX_DOMINANT
				: RX_RECESSIVE;
			// RULE3 tx low drives dominant
			if (!pinIn.txIn) begin
				next_st.out.busHighOut = 1'h1;
				next_st.out.busHighOe_n = OE_DRIVE;
				next_st.out.busLowOut = 1'h0;
				next_st.out.busLowOe_n = OE_DRIVE;
			end else begin
				next_st.out.busHighOut = 1'h0;
				next_st.out.busHighOe_n = OE_RELEASE;
				next_st.out.busLowOut = 1'h0;
				next_st.out.busLowOe_n = OE_RELEASE;
			end
			next_st.out.biasGround = 1'h0;
		end else begin
			// RULE1 RULE17 high select is standby
			// RULE4 driver off, weak ground bias
			next_st.out.busHighOut = 1'h0;
			next_st.out.busHighOe_n = OE_RELEASE;
			next_st.out.busLowOut = 1'h0;
			next_st.out.busLowOe_n = OE_RELEASE;
			next_st.out.biasGround = 1'h1;
			// RULE8 RULE9 only filtered edges advance
			case (st.mon)
				MON_IDLE: begin
					if (newDom) begin
						next_st.mon = MON_WAIT_REC;
						// RULE15 window from dominant start
						next_st.winCnt = CNT_W'(FILTER_CYC + 1);
					end
				end
				MON_WAIT_REC: begin
					if (newRec) begin
						next_st.mon = MON_WAIT_DOM;
					end
				end
				MON_WAIT_DOM: begin
					if (newDom) begin
						next_st.mon = MON_WOKEN;
					end
				end
				MON_WOKEN: begin
					next_st.mon = MON_WOKEN;
				end
				default: begin
					next_st.mon = MON_IDLE;
				end
			endcase
			// RULE16 window expiry restarts monitor
			if ((st.mon == MON_WAIT_REC || st.mon == MON_WAIT_DOM)
				&& st.winCnt >= CNT_W'(WINDOW_CYC)
				&& next_st.mon != MON_WOKEN) begin
				next_st.mon = MON_IDLE;
			end
			// RULE10 RULE11 rx low per filtered dominant
			if (next_st.mon == MON_WOKEN && next_st.filtDom) begin
				next_st.out.rxOut = RX_DOMINANT;
			end else begin
				next_st.out.rxOut = RX_RECESSIVE;
			end
		end
		// RULE6 event only from this channel
		if (evtTaken) begin
			next_st.pend = 1'h0;
		end
		if (st.mon == MON_WAIT_DOM && next_st.mon == MON_WOKEN) begin
			next_st.pend = 1'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st.mon <= MON_IDLE;
			st.lastDom <= 1'h0;
			st.runCnt <= '0;
			st.filtDom <= 1'h0;
			st.winCnt <= '0;
			st.pend <= 1'h0;
			st.out.rxOut <= RX_RECESSIVE;
			st.out.busHighOut <= 1'h0;
			st.out.busHighOe_n <= OE_RELEASE;
			st.out.busLowOut <= 1'h0;
			st.out.busLowOe_n <= OE_RELEASE;
			st.out.biasGround <= 1'h1;
		end else begin
			st <= next_st;
		end
	end

	assign pinOut = st.out;
	assign evtPend = st.pend;

endmodule : can_phy_channel

// ****************************************
// dual transceiver top
// ****************************************
module dual_can_phy_mode_wake #(
	// RULE18 filter and window cycle counts
	parameter int FILTER_CYC = can_phy_pkg::WAKE_FILTER_CYC,
	parameter int WINDOW_CYC = can_phy_pkg::WAKE_WINDOW_CYC
) (
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	// channel 1
	input  wire can_phy_pkg::chanIn_t  pinInCh1,
	output var  can_phy_pkg::chanOut_t pinOutCh1,
	// channel 2
	input  wire can_phy_pkg::chanIn_t  pinInCh2,
	output var  can_phy_pkg::chanOut_t pinOutCh2,
	// wake event stream
	output var  can_phy_pkg::wakeEvt_t wakeEvt,
	input  wire logic                  wakeReady
);
	import can_phy_pkg::*;

	chanIn_t              chIn [NUM_CH];
	chanOut_t             chOut [NUM_CH];
	logic [NUM_CH-1:0]    pend;
	logic [NUM_CH-1:0]    taken;
	logic                 fifoReady;
	logic                 pickCh;

	assign chIn[0] = pinInCh1;
	assign chIn[1] = pinInCh2;
	assign pinOutCh1 = chOut[0];
	assign pinOutCh2 = chOut[1];
	assign pickCh = !pend[0];

	// RULE19 two independent channels
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : gCh
			assign taken[g] = fifoReady && pend[g]
				&& (pickCh == 1'(g));
			can_phy_channel #(
				.FILTER_CYC (FILTER_CYC),
				.WINDOW_CYC (WINDOW_CYC)
			) uChan (
				.clk      (clk),
				.rst_n    (rst_n),
				.pinIn    (chIn[g]),
				.pinOut   (chOut[g]),
				.evtPend  (pend[g]),
				.evtTaken (taken[g])
			);
		end
	endgenerate

	wake_fifo #(
		.WIDTH (EVT_W),
		.DEPTH (FIFO_DEPTH)
	) uFifo (
		.clk      (clk),
		.rst_n    (rst_n),
		.inValid  (|pend),
		.inData   (pickCh),
		.inReady  (fifoReady),
		.outValid (wakeEvt.valid),
		.outData  (wakeEvt.data),
		.outReady (wakeReady)
	);

endmodule : dual_can_phy_mode_wake

`default_nettype wire

/* tb/can_phy_props.sv */
`timescale 1ns/100ps
`default_nettype none
// ****
// pin and wake checks
// ****
module can_phy_props #(
	parameter int FILTER_CYC = 3,
	parameter int WINDOW_CYC = 60
) (
	// watched ports
	input wire logic                  clk,
	input wire logic                  rst_n,
	input wire can_phy_pkg::chanIn_t  pinInCh1,
	input wire can_phy_pkg::chanOut_t pinOutCh1,
	input wire can_phy_pkg::chanIn_t  pinInCh2,
	input wire can_phy_pkg::chanOut_t pinOutCh2,
	input wire can_phy_pkg::wakeEvt_t wakeEvt,
	input wire logic                  wakeReady
);
	import can_phy_pkg::*;
	int domRun;
	always_ff @(posedge clk) begin
		if (!rst_n || !pinInCh1.busDominant) begin
			domRun <= 0;
		end else begin
			domRun <= domRun + 1;
		end
	end
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	sequence s_woken;
		!pinOutCh1.rxOut && pinInCh1.standby && $past(pinInCh1.standby);
	endsequence
	property p_drive;
		!pinInCh1.standby |=> pinOutCh1.busHighOe_n == $past(pinInCh1.txIn)
			&& pinOutCh1.busLowOe_n == $past(pinInCh1.txIn);
	endproperty
	property p_mirror;
		!pinInCh1.standby |=> pinOutCh1.rxOut == !$past(pinInCh1.busDominant);
	endproperty
	property p_release;
		pinInCh1.standby |=> pinOutCh1.busHighOe_n && pinOutCh1.busLowOe_n
			&& pinOutCh1.biasGround;
	endproperty
	property p_sbRec;
		pinInCh1.standby && !pinInCh1.busDominant |=> pinOutCh1.rxOut;
	endproperty
	property p_ch2Rec;
		pinInCh2.standby && !pinInCh2.busDominant |=> pinOutCh2.rxOut;
	endproperty
	property p_filt;
		$fell(pinOutCh1.rxOut) && $past(pinInCh1.standby) |-> domRun > FILTER_CYC;
	endproperty
	property p_wakeHold;
		s_woken ##0 pinInCh1.busDominant |=> !pinOutCh1.rxOut;
	endproperty
	property p_evtHold;
		wakeEvt.valid && !wakeReady |=> wakeEvt.valid && $stable(wakeEvt.data);
	endproperty
	property p_drvLevel;
		!pinInCh1.standby |=>
			pinOutCh1.busHighOut == !$past(pinInCh1.txIn)
			&& !pinOutCh1.busLowOut;
	endproperty
	property p_ch2Drive;
		!pinInCh2.standby |=>
			pinOutCh2.busHighOe_n == $past(pinInCh2.txIn)
			&& pinOutCh2.busLowOe_n == $past(pinInCh2.txIn);
	endproperty
	a_drive: assert property (p_drive) else $error("drive");
	a_mirror: assert property (p_mirror) else $error("mirror");
	a_release: assert property (p_release) else $error("release");
	a_sbRec: assert property (p_sbRec) else $error("standby rx");
	a_ch2Rec: assert property (p_ch2Rec) else $error("ch2 rx");
	a_filt: assert property (p_filt) else $error("filter");
	a_wakeHold: assert property (p_wakeHold) else $error("wake low");
	a_evtHold: assert property (p_evtHold) else $error("event held");
	a_drvLevel: assert property (p_drvLevel) else $error("level");
	a_ch2Drive: assert property (p_ch2Drive) else $error("ch2 oe");
endmodule : can_phy_props
bind dual_can_phy_mode_wake can_phy_props #(
	.FILTER_CYC(FILTER_CYC),
	.WINDOW_CYC(WINDOW_CYC)
) i_props (.clk(clk), .rst_n(rst_n), .pinInCh1(pinInCh1),
	.pinOutCh1(pinOutCh1), .pinInCh2(pinInCh2), .pinOutCh2(pinOutCh2),
	.wakeEvt(wakeEvt), .wakeReady(wakeReady));
`default_nettype wire

/* tb/can_ctrl_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ****
// host controller model
// ****
module can_ctrl_model (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// bench requests
	input  wire logic reqStandby,
	input  wire logic reqTx,
	// transceiver side
	input  wire logic rxOut,
	output var  logic standby,
	output var  logic txIn
);
	logic rxPrev;
	logic woke;
	initial begin
		standby = 1'h1;
		txIn = 1'h1;
	end
	always @(posedge clk) begin
		rxPrev <= rxOut;
		txIn <= reqTx;
		if (!rst_n) begin
			woke <= 1'h0;
			standby <= 1'h1;
		end else begin
			woke <= reqStandby && (woke || (standby && rxPrev && !rxOut));
			standby <= reqStandby && !(woke || (standby && rxPrev && !rxOut));
		end
	end
endmodule : can_ctrl_model
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
// ****
// bench top
// ****
module tb_top;
	import can_phy_pkg::*;
	logic clk, rst_n, reqSb, reqTx, sb1, tx1, sb2, tx2, wakeReady;
	logic [1:0] bus;
	chanIn_t pinInCh1, pinInCh2;
	chanOut_t pinOutCh1, pinOutCh2;
	wakeEvt_t wakeEvt;
	int failures, n_checks;
	assign pinInCh1 = {sb1, tx1, bus[0]};
	assign pinInCh2 = {sb2, tx2, bus[1]};
	dual_can_phy_mode_wake #(.FILTER_CYC(3), .WINDOW_CYC(60)) i_dut (
		.clk(clk), .rst_n(rst_n), .pinInCh1(pinInCh1), .pinOutCh1(pinOutCh1),
		.pinInCh2(pinInCh2), .pinOutCh2(pinOutCh2), .wakeEvt(wakeEvt),
		.wakeReady(wakeReady));
	can_ctrl_model i_host (.clk(clk), .rst_n(rst_n), .reqStandby(reqSb),
		.reqTx(reqTx), .rxOut(pinOutCh1.rxOut), .standby(sb1), .txIn(tx1));
	task automatic report_and_stop();
		if (failures == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input string nm, input logic exp, input logic got);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s exp %h got %h", nm, exp, got);
		end
	endtask : chk
	task automatic run(input int ch, input logic d, input int n);
		repeat (n) begin
			@(posedge clk);
			bus[ch] <= d;
		end
	endtask : run
	task automatic takeEvt(input logic d);
		int i;
		for (i = 0; i < 10 && wakeEvt.valid !== 1'h1; i++) begin
			@(posedge clk);
			#1;
		end
		if (i == 10) begin
			failures++;
			report_and_stop();
		end
		chk("wake channel", d, wakeEvt.data);
		@(posedge clk);
		wakeReady <= 1'h1;
		@(posedge clk);
		wakeReady <= 1'h0;
		#1;
		chk("drained", 1'h0, wakeEvt.valid);
	endtask : takeEvt
	task automatic t_normal();
		@(posedge clk);
		reqSb <= 1'h0;
		for (int k = 0; k < 4; k++) begin
			reqTx <= k[0];
			bus[0] <= k[1];
			repeat (4) @(posedge clk);
			#1;
			chk("drive", k[0], pinOutCh1.busHighOe_n);
			chk("low oe", k[0], pinOutCh1.busLowOe_n);
			chk("high out", !k[0], pinOutCh1.busHighOut);
			chk("low out", 1'h0, pinOutCh1.busLowOut);
			chk("rx", !k[1], pinOutCh1.rxOut);
			@(posedge clk);
		end
	endtask : t_normal
	task automatic t_wake();
		@(posedge clk);
		reqSb <= 1'h1;
		reqTx <= 1'h0;
		bus[0] <= 1'h0;
		repeat (4) @(posedge clk);
		run(0, 1'h1, 3);
		#1;
		chk("oe", 1'h1, pinOutCh1.busHighOe_n);
		chk("bias", 1'h1, pinOutCh1.biasGround);
		chk("rx sb", 1'h1, pinOutCh1.rxOut);
		run(0, 1'h1, 7);
		run(0, 1'h0, 3);
		run(0, 1'h1, 3);
		run(0, 1'h0, 7);
		run(0, 1'h1, 7);
		#1;
		chk("wake rx", 1'h0, pinOutCh1.rxOut);
		chk("other rx", 1'h1, pinOutCh2.rxOut);
		repeat (2) @(posedge clk);
		#1;
		chk("host normal", 1'h0, sb1);
		takeEvt(1'h0);
	endtask : t_wake
	task automatic t_window();
		run(1, 1'h1, 7);
		run(1, 1'h0, 70);
		run(1, 1'h1, 7);
		#1;
		chk("late rx", 1'h1, pinOutCh2.rxOut);
		run(1, 1'h0, 7);
		run(1, 1'h1, 7);
		#1;
		chk("new rx", 1'h0, pinOutCh2.rxOut);
		takeEvt(1'h1);
		run(1, 1'h0, 7);
		run(1, 1'h1, 3);
		#1;
		chk("short dom", 1'h1, pinOutCh2.rxOut);
		run(1, 1'h1, 5);
		#1;
		chk("again", 1'h0, pinOutCh2.rxOut);
	endtask : t_window
	task automatic t_ch2();
		@(posedge clk);
		sb2 <= 1'h0;
		tx2 <= 1'h0;
		reqTx <= 1'h1;
		bus[1] <= 1'h0;
		repeat (3) @(posedge clk);
		#1;
		chk("ch2 oe", 1'h0, pinOutCh2.busHighOe_n);
		chk("ch2 high", 1'h1, pinOutCh2.busHighOut);
		chk("ch2 bias", 1'h0, pinOutCh2.biasGround);
		chk("ch2 rx", 1'h1, pinOutCh2.rxOut);
		chk("ch1 oe", 1'h1, pinOutCh1.busHighOe_n);
	endtask : t_ch2
	initial begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		{rst_n, reqSb, reqTx, sb2, tx2, bus, wakeReady} = 8'h3C;
		failures = 0;
		n_checks = 0;
		repeat (10) @(posedge clk);
		rst_n <= 1'h1;
		#1;
		chk("reset rx", 1'h1, pinOutCh1.rxOut);
		t_normal();
		t_wake();
		t_window();
		t_ch2();
		report_and_stop();
	end
endmodule : tb_top
`default_nettype wire
